// ---- pwpr_cfg.svh ----
/*
 Constants of the power to pulse rate converter: widths, shifts, thresholds and timing counts.
 Assumes the block clock doubles as the oscillator whose rate all output rates follow.
*/
`ifndef PWPR_CFG_SVH
`define PWPR_CFG_SVH

// ***************************************************
// Widths
// ***************************************************
`define PWPR_POWER_W 16
`define PWPR_ACC_W 40
`define PWPR_CNT_W 32
`define PWPR_MULT_W 12

// ***************************************************
// Rate scaling
// ***************************************************
// Full scale power divided by 0.204, so full scale gives 0.204 of the base rate.
`define PWPR_LOW_SCALE 40'h000004E6E2
// Base divide exponent for select code 00; the code is subtracted from it.
`define PWPR_BASE_EXP 5'h13
// Calibration threshold shifts relative to the scale constant.
`define PWPR_CF_SHIFT_SCALE_HI 6'h0C
`define PWPR_CF_SHIFT_SCALE_LO 6'h0D
`define PWPR_CF_SHIFT_HF 6'h05
// Calibration multiple exponents.
`define PWPR_MULT_EXP_HI 4'h7
`define PWPR_MULT_EXP_LO 4'h6
`define PWPR_MULT_EXP_HF 4'hB
// Power below this value is below 0.00249 percent of the base rate.
`define PWPR_NOLOAD_MIN 16'h0008

// ***************************************************
// Timing
// ***************************************************
`define PWPR_CLK_HZ 64'd40000000
`define PWPR_LOW_WIDTH_MS 64'd120
`define PWPR_CF_WIDTH_MS 64'd90
`define PWPR_HF_WIDTH_US 64'd35
`define PWPR_LOW_WIDTH_CYC ((`PWPR_LOW_WIDTH_MS * `PWPR_CLK_HZ) / 64'd1000)
`define PWPR_CF_WIDTH_CYC ((`PWPR_CF_WIDTH_MS * `PWPR_CLK_HZ) / 64'd1000)
`define PWPR_HF_WIDTH_CYC ((`PWPR_HF_WIDTH_US * `PWPR_CLK_HZ) / 64'd1000000)

`endif

// ---- pwpr_pkg.sv ----
/*
 Types of the power to pulse rate converter.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package pwpr_pkg;

   // ***************************************************
   // Low-rate output alternation
   // ***************************************************
   typedef enum logic [1:0] {
      PWPR_NEXT_A = 2'b01,
      PWPR_NEXT_B = 2'b10
   } pwpr_side_t;

endpackage

// ---- pwpr_pulse_if.sv ----
/*
 Interface between the converter core and one pulse shaper.
 Assumes one clock shared by both ends.
*/
`timescale 1ns/1ps
`include "pwpr_cfg.svh"

interface pwpr_pulse_if;
   logic trigger;
   logic fixed_width;
   logic [`PWPR_CNT_W-1:0] nominal_width;
   logic active;

   modport ctrl (output trigger, output fixed_width, output nominal_width, input active);
   modport shaper (input trigger, input fixed_width, input nominal_width, output active);
endinterface

// ---- pwpr_pulse_shaper.sv ----
/*
 Pulse shaper: stretches a one-cycle trigger into a pulse of nominal width, or, unless fixed_width is set, half the last period if shorter.
 Assumes triggers come from logic on the same clock.
*/
`timescale 1ns/1ps
`include "pwpr_cfg.svh"

module pwpr_pulse_shaper (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   pwpr_pulse_if.shaper port
);

   logic [`PWPR_CNT_W-1:0] period;
   logic [`PWPR_CNT_W-1:0] left;
   logic [`PWPR_CNT_W-1:0] next_period;
   logic [`PWPR_CNT_W-1:0] next_left;
   logic [`PWPR_CNT_W-1:0] half;

   // ***************************************************
   // Width and period tracking
   // ***************************************************
   always_comb begin
      half = period >> 1;
      next_period = (period == {`PWPR_CNT_W{1'b1}}) ? period : period + 1'b1;
      next_left = (left != '0) ? left - 1'b1 : left;
      if (port.trigger) begin
         next_period = {{(`PWPR_CNT_W-1){1'b0}}, 1'b1};
         if (port.fixed_width || half >= port.nominal_width) begin
            next_left = port.nominal_width;
         end else begin
            // A fast rate shrinks the pulse to half its period.
            next_left = (half == '0) ? {{(`PWPR_CNT_W-1){1'b0}}, 1'b1} : half;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         period <= {`PWPR_CNT_W{1'b1}};
         left <= '0;
      end else if (ce) begin
         period <= next_period;
         left <= next_left;
      end
   end

   assign port.active = (left != '0);

endmodule

// ---- pwpr_converter.sv ----
/*
 Digital-to-frequency stage of an energy meter: accumulates filtered power and emits
 two alternating active-low low-rate pulses and one calibration pulse.
 Assumes POWER_IN is the filtered power from logic on REF_CLK_IN, unsigned, full scale 16'hFFFF,
 and that the selects are asynchronous pins.
*/
`timescale 1ns/1ps
`include "pwpr_cfg.svh"

module pwpr_converter #(
   parameter logic [`PWPR_CNT_W-1:0] LOW_WIDTH_CYC = `PWPR_CNT_W'(`PWPR_LOW_WIDTH_CYC),
   parameter logic [`PWPR_CNT_W-1:0] CF_WIDTH_CYC = `PWPR_CNT_W'(`PWPR_CF_WIDTH_CYC)
) (
   // Clock, reset and enable
   input wire logic REF_CLK_IN,
   input wire logic RST_IN,
   input wire logic CE_IN,
   // Filtered power
   input wire logic [`PWPR_POWER_W-1:0] POWER_IN,
   // Select pins
   input wire logic RATE_SELECT_LOW_IN,
   input wire logic RATE_SELECT_HIGH_IN,
   input wire logic CALIBRATION_SCALE_SELECT_IN,
   // Pulse outputs
   output logic LOW_RATE_PULSE_A_N_OUT,
   output logic LOW_RATE_PULSE_B_N_OUT,
   output logic CALIBRATION_PULSE_OUT
);

   localparam logic [`PWPR_CNT_W-1:0] HF_WIDTH_CYC = `PWPR_CNT_W'(`PWPR_HF_WIDTH_CYC);

   // ***************************************************
   // Select synchronisers
   // ***************************************************
   logic [2:0] sel_meta;
   logic [2:0] sel_sync;

   always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         sel_meta <= 3'h0;
         sel_sync <= 3'h0;
      end else if (CE_IN) begin
         // Two stages so a moving select never splits the ratio and multiple.
         sel_meta <= {CALIBRATION_SCALE_SELECT_IN, RATE_SELECT_HIGH_IN, RATE_SELECT_LOW_IN};
         sel_sync <= sel_meta;
      end
   end

   // ***************************************************
   // Ratio decode
   // ***************************************************
   logic [1:0] rate_code;
   logic scale_hi;
   logic hf_mode;
   logic [5:0] cf_shift;
   logic [3:0] mult_exp;
   logic [`PWPR_ACC_W-1:0] cf_thr;
   logic [`PWPR_MULT_W-1:0] mult_last;

   always_comb begin
      rate_code = sel_sync[1:0];
      scale_hi = sel_sync[2];
      hf_mode = !scale_hi && (rate_code == 2'h3);
      // Low threshold is scale << (19 - code); the multiple divides it down.
      if (scale_hi) begin
         cf_shift = `PWPR_CF_SHIFT_SCALE_HI;
         mult_exp = `PWPR_MULT_EXP_HI - {2'h0, rate_code};
      end else if (hf_mode) begin
         cf_shift = `PWPR_CF_SHIFT_HF;
         mult_exp = `PWPR_MULT_EXP_HF;
      end else begin
         cf_shift = `PWPR_CF_SHIFT_SCALE_LO;
         mult_exp = `PWPR_MULT_EXP_LO - {2'h0, rate_code};
      end
      cf_thr = `PWPR_LOW_SCALE << cf_shift;
      mult_last = (`PWPR_MULT_W'(1) << mult_exp) - 1'b1;
   end

   // ***************************************************
   // Accumulation
   // ***************************************************
   logic [`PWPR_ACC_W-1:0] acc;
   logic [`PWPR_ACC_W-1:0] next_acc;
   logic [`PWPR_ACC_W-1:0] sum;
   logic [`PWPR_MULT_W-1:0] mult_cnt;
   logic [`PWPR_MULT_W-1:0] next_mult_cnt;
   logic cf_event;
   logic low_event;

   always_comb begin
      // One add per oscillator cycle, so every rate tracks the clock.
      sum = acc + {{(`PWPR_ACC_W-`PWPR_POWER_W){1'b0}}, POWER_IN};
      next_acc = acc;
      cf_event = 1'b0;
      if (POWER_IN >= `PWPR_NOLOAD_MIN) begin
         next_acc = sum;
         if (sum >= cf_thr) begin
            next_acc = sum - cf_thr;
            cf_event = 1'b1;
         end
      end
      // The low-rate path integrates many calibration periods, which averages out ripple.
      next_mult_cnt = mult_cnt;
      low_event = 1'b0;
      if (cf_event) begin
         if (mult_cnt >= mult_last) begin
            next_mult_cnt = '0;
            low_event = 1'b1;
         end else begin
            next_mult_cnt = mult_cnt + 1'b1;
         end
      end
   end

   always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         acc <= '0;
         mult_cnt <= '0;
      end else if (CE_IN) begin
         acc <= next_acc;
         mult_cnt <= next_mult_cnt;
      end
   end

   // ***************************************************
   // Pulse shaping
   // ***************************************************
   pwpr_pulse_if low_if ();
   pwpr_pulse_if cf_if ();

   assign low_if.trigger = low_event;
   assign low_if.fixed_width = 1'b0;
   assign low_if.nominal_width = LOW_WIDTH_CYC;
   assign cf_if.trigger = cf_event;
   assign cf_if.fixed_width = hf_mode;
   assign cf_if.nominal_width = hf_mode ? HF_WIDTH_CYC : CF_WIDTH_CYC;

   pwpr_pulse_shaper low_shaper (
      .clk(REF_CLK_IN),
      .rst(RST_IN),
      .ce(CE_IN),
      .port(low_if.shaper)
   );

   pwpr_pulse_shaper cf_shaper (
      .clk(REF_CLK_IN),
      .rst(RST_IN),
      .ce(CE_IN),
      .port(cf_if.shaper)
   );

   // ***************************************************
   // Output alternation and registers
   // ***************************************************
   pwpr_pkg::pwpr_side_t side;
   pwpr_pkg::pwpr_side_t next_side;
   pwpr_pkg::pwpr_side_t pulse_side;
   pwpr_pkg::pwpr_side_t next_pulse_side;
   logic next_a_n;
   logic next_b_n;
   logic next_cf;

   always_comb begin
      next_side = side;
      next_pulse_side = pulse_side;
      if (low_event) begin
         // A retrigger moves the pulse to the other output.
         next_pulse_side = side;
         unique case (side)
            pwpr_pkg::PWPR_NEXT_A: begin
               next_side = pwpr_pkg::PWPR_NEXT_B;
            end
            pwpr_pkg::PWPR_NEXT_B: begin
               next_side = pwpr_pkg::PWPR_NEXT_A;
            end
            default: begin
               next_side = pwpr_pkg::PWPR_NEXT_A;
            end
         endcase
      end
      next_a_n = !(low_if.active && pulse_side == pwpr_pkg::PWPR_NEXT_A);
      next_b_n = !(low_if.active && pulse_side == pwpr_pkg::PWPR_NEXT_B);
      next_cf = cf_if.active;
   end

   always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         side <= pwpr_pkg::PWPR_NEXT_A;
         pulse_side <= pwpr_pkg::PWPR_NEXT_A;
         LOW_RATE_PULSE_A_N_OUT <= 1'b1;
         LOW_RATE_PULSE_B_N_OUT <= 1'b1;
         CALIBRATION_PULSE_OUT <= 1'b0;
      end else if (CE_IN) begin
         side <= next_side;
         pulse_side <= next_pulse_side;
         LOW_RATE_PULSE_A_N_OUT <= next_a_n;
         LOW_RATE_PULSE_B_N_OUT <= next_b_n;
         CALIBRATION_PULSE_OUT <= next_cf;
      end
   end

endmodule

// ---- pwpr_converter_assertions.sv ----
/*
 Checker for the power to pulse rate converter ports.
 Assumes a bind onto pwpr_converter and one clock domain.
*/
`timescale 1ns/1ps
`include "pwpr_cfg.svh"

module pwpr_converter_assertions #(
   parameter logic [`PWPR_CNT_W-1:0] LOW_WIDTH_CYC = 32'h28,
   parameter logic [`PWPR_CNT_W-1:0] CF_WIDTH_CYC = 32'h1E
) (
   // Clock and control
   input wire logic REF_CLK_IN,
   input wire logic RST_IN,
   input wire logic CE_IN,
   input wire logic [`PWPR_POWER_W-1:0] POWER_IN,
   input wire logic RATE_SELECT_LOW_IN,
   input wire logic RATE_SELECT_HIGH_IN,
   input wire logic CALIBRATION_SCALE_SELECT_IN,
   // Pulses
   input wire logic LOW_RATE_PULSE_A_N_OUT,
   input wire logic LOW_RATE_PULSE_B_N_OUT,
   input wire logic CALIBRATION_PULSE_OUT
);
   // ***************************************************
   // Pulse length counters
   // ***************************************************
   logic [31:0] cf_len;
   logic [31:0] low_len;
   logic [31:0] next_cf_len;
   logic [31:0] next_low_len;
   logic hf_mode;
   assign hf_mode = !CALIBRATION_SCALE_SELECT_IN && RATE_SELECT_HIGH_IN && RATE_SELECT_LOW_IN;
   always_comb begin
      next_cf_len = CALIBRATION_PULSE_OUT ? cf_len + 32'h1 : 32'h0;
      next_low_len = !LOW_RATE_PULSE_A_N_OUT ? low_len + 32'h1 : 32'h0;
   end
   always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         cf_len <= 32'h0;
         low_len <= 32'h0;
      end else begin
         cf_len <= next_cf_len;
         low_len <= next_low_len;
      end
   end

   // ***************************************************
   // Properties
   // ***************************************************
   default clocking cb @(posedge REF_CLK_IN); endclocking
   default disable iff (RST_IN);
   sequence s_cf_end;
      $fell(CALIBRATION_PULSE_OUT);
   endsequence
   sequence s_low_start;
      $fell(LOW_RATE_PULSE_A_N_OUT) || $fell(LOW_RATE_PULSE_B_N_OUT);
   endsequence
   a_release_idle: assert property ($fell(RST_IN) |-> LOW_RATE_PULSE_A_N_OUT &&
      LOW_RATE_PULSE_B_N_OUT && !CALIBRATION_PULSE_OUT) else $error("Outputs busy after reset.");
   a_lows_exclusive: assert property (LOW_RATE_PULSE_A_N_OUT || LOW_RATE_PULSE_B_N_OUT)
      else $error("Both low-rate outputs active.");
   a_noload_quiet: assert property ((CE_IN && POWER_IN < `PWPR_NOLOAD_MIN)[*4] |=>
      !$rose(CALIBRATION_PULSE_OUT)) else $error("Calibration pulse without load.");
   a_ce_freeze: assert property (!CE_IN |=> $stable({LOW_RATE_PULSE_A_N_OUT,
      LOW_RATE_PULSE_B_N_OUT, CALIBRATION_PULSE_OUT})) else $error("Output moved while disabled.");
   a_hf_width: assert property (s_cf_end and hf_mode |-> cf_len >= `PWPR_HF_WIDTH_CYC)
      else $error("High-frequency pulse too short.");
   a_cf_width: assert property (s_cf_end and !hf_mode |-> cf_len <= CF_WIDTH_CYC)
      else $error("Calibration pulse too long.");
   a_low_width: assert property ($rose(LOW_RATE_PULSE_A_N_OUT) |-> low_len <= LOW_WIDTH_CYC)
      else $error("Low-rate pulse too long.");
   a_low_with_cf: assert property (s_low_start |-> CALIBRATION_PULSE_OUT)
      else $error("Low-rate pulse without calibration pulse.");
endmodule

bind pwpr_converter pwpr_converter_assertions #(.LOW_WIDTH_CYC(LOW_WIDTH_CYC), .CF_WIDTH_CYC(CF_WIDTH_CYC)) chk (
   .REF_CLK_IN(REF_CLK_IN), .RST_IN(RST_IN), .CE_IN(CE_IN), .POWER_IN(POWER_IN),
   .RATE_SELECT_LOW_IN(RATE_SELECT_LOW_IN), .RATE_SELECT_HIGH_IN(RATE_SELECT_HIGH_IN),
   .CALIBRATION_SCALE_SELECT_IN(CALIBRATION_SCALE_SELECT_IN), .LOW_RATE_PULSE_A_N_OUT(LOW_RATE_PULSE_A_N_OUT),
   .LOW_RATE_PULSE_B_N_OUT(LOW_RATE_PULSE_B_N_OUT), .CALIBRATION_PULSE_OUT(CALIBRATION_PULSE_OUT));

// ---- pwpr_meter_model.sv ----
/*
 Pulse counter standing in for the meter register or counter input.
 Assumes the same clock as the converter.
*/
`timescale 1ns/1ps

module pwpr_meter_model (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // Pulses
   input wire logic low_a_n_in,
   input wire logic low_b_n_in,
   input wire logic cf_in,
   // Tallies
   output logic [31:0] cf_count_out,
   output logic [31:0] low_count_out,
   output logic [31:0] cf_width_out
);
   logic [2:0] prev;
   logic [31:0] run;
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         prev <= 3'h6;
         run <= 32'h0;
         cf_count_out <= 32'h0;
         low_count_out <= 32'h0;
         cf_width_out <= 32'h0;
      end else begin
         prev <= {low_a_n_in, low_b_n_in, cf_in};
         run <= cf_in ? run + 32'h1 : 32'h0;
         if (cf_in && !prev[0]) cf_count_out <= cf_count_out + 32'h1;
         if (!cf_in && prev[0]) cf_width_out <= run;
         if ((!low_a_n_in && prev[2]) || (!low_b_n_in && prev[1])) low_count_out <= low_count_out + 32'h1;
      end
   end
endmodule

// ---- testbench.sv ----
/*
 Self-checking bench for the power to pulse rate converter.
 Assumes the checker is bound in and the meter model counts pulses.
*/
`timescale 1ns/1ps
`include "pwpr_cfg.svh"

module testbench;
   logic REF_CLK_IN = 1'b0;
   logic RST_IN = 1'b1;
   logic CE_IN = 1'b1;
   logic [15:0] POWER_IN = 16'h0;
   logic RATE_SELECT_LOW_IN = 1'b0;
   logic RATE_SELECT_HIGH_IN = 1'b0;
   logic CALIBRATION_SCALE_SELECT_IN = 1'b0;
   logic a_n, b_n, cf;
   logic [31:0] cf_count, low_count, cf_width;
   int fail_count = 0;
   int checked = 0;
   longint acc = 0;
   longint thr = 0;
   logic [31:0] n_cf = 32'h0;

   always #12.5 REF_CLK_IN = ~REF_CLK_IN;

   pwpr_converter #(.LOW_WIDTH_CYC(32'h28), .CF_WIDTH_CYC(32'h1E)) dut (.REF_CLK_IN(REF_CLK_IN),
      .RST_IN(RST_IN), .CE_IN(CE_IN), .POWER_IN(POWER_IN), .RATE_SELECT_LOW_IN(RATE_SELECT_LOW_IN),
      .RATE_SELECT_HIGH_IN(RATE_SELECT_HIGH_IN), .CALIBRATION_SCALE_SELECT_IN(CALIBRATION_SCALE_SELECT_IN),
      .LOW_RATE_PULSE_A_N_OUT(a_n), .LOW_RATE_PULSE_B_N_OUT(b_n), .CALIBRATION_PULSE_OUT(cf));
   pwpr_meter_model meter (.clk_in(REF_CLK_IN), .rst_in(RST_IN), .low_a_n_in(a_n), .low_b_n_in(b_n),
      .cf_in(cf), .cf_count_out(cf_count), .low_count_out(low_count), .cf_width_out(cf_width));

   task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   task end_sim;
      $display("Checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   // One enabled or frozen cycle; the model keeps the residue, as the design must.
   task cyc(input int p, input bit ce);
      @(posedge REF_CLK_IN);
      #2;
      POWER_IN = p[15:0];
      CE_IN = ce;
      if (ce && p >= `PWPR_NOLOAD_MIN) begin
         acc = acc + p;
         if (acc >= thr) begin
            acc = acc - thr;
            n_cf = n_cf + 32'h1;
         end
      end
   endtask

   task setm(input logic calibration_scale_select, input logic s1, input logic s0, input int sh);
      @(posedge REF_CLK_IN);
      #2;
      CALIBRATION_SCALE_SELECT_IN = calibration_scale_select;
      RATE_SELECT_HIGH_IN = s1;
      RATE_SELECT_LOW_IN = s0;
      thr = longint'(`PWPR_LOW_SCALE) << sh;
      repeat (4) cyc(0, 1'b1);
   endtask

   initial begin
      repeat (3) @(posedge REF_CLK_IN);
      #2;
      RST_IN = 1'b0;
      chk("idle outputs", {29'h0, a_n, b_n, cf}, 32'h6);
      void'($urandom(32'h52E8));
      // High-frequency mode with random load and random freezes.
      setm(1'b0, 1'b1, 1'b1, `PWPR_CF_SHIFT_HF);
      repeat (30000) cyc($urandom % 7001, ($urandom % 8) != 0);
      repeat (10) cyc(0, 1'b1);
      chk("cf count random", cf_count, n_cf);
      // Park just below the threshold; sub-minimum load must not tip it over.
      // The last step must stay within the 16-bit input, so stop one full step plus the minimum short.
      while (thr - acc > 65543) cyc(65535, 1'b1);
      cyc(int'(thr - acc - 64'sd8), 1'b1);
      repeat (20) cyc(7, 1'b1);
      repeat (5) cyc(0, 1'b1);
      chk("cf count noload", cf_count, n_cf);
      cyc(8, 1'b1);
      repeat (1500) cyc(0, 1'b1);
      chk("cf count minimum", cf_count, n_cf);
      chk("hf width", cf_width, 32'(`PWPR_HF_WIDTH_CYC));
      // Full scale with scale select high, slowest base rate.
      setm(1'b1, 1'b0, 1'b0, `PWPR_CF_SHIFT_SCALE_HI);
      repeat (45000) cyc(65535, 1'b1);
      repeat (10) cyc(0, 1'b1);
      chk("cf count full", cf_count, n_cf);
      chk("cf width", cf_width, 32'h1E);
      chk("low count", low_count, 32'h0);
      chk("low outputs idle", {30'h0, a_n, b_n}, 32'h3);
      end_sim;
   end

   // Tests take about 80000 cycles; the limit keeps the run under 95000 cycles.
   initial begin
      #2375000;
      fail_count++;
      end_sim;
   end
endmodule
